// >>> logic/serial_host_defs.vh
`ifndef SERIAL_HOST_DEFS_VH
`define SERIAL_HOST_DEFS_VH
// ==========================================
// register offsets of the controller
`define REG_CTRL 4'h0
`define REG_STATUS 4'h1
`define REG_TXDATA 4'h2
`define REG_RXDATA 4'h3
`define REG_TWI_CTRL 4'h4
`define REG_TWI_STATUS 4'h5
`define REG_DIV 4'h6
// ==========================================
// control fields
`define CTRL_SPI_GO 0
`define CTRL_TWI_EN 1
`define CTRL_MODE_LSB 4
`define CTRL_MODE_MSB 7
// ==========================================
// status fields
`define ST_SPI_BUSY 0
`define ST_SPI_DONE 1
`define ST_TWI_BUSY 2
`define ST_TWI_DONE 3
`define ST_ARB_LOST 4
`define ST_NACK 5
`define ST_BUS_BUSY 6
// ==========================================
// twi command fields
`define TWI_START 0
`define TWI_STOP 1
`define TWI_READ 2
`define TWI_ACK_OUT 3
// ==========================================
// mode code for select-controlled client
`define MODE_CLIENT_SEL 4'h4
// ==========================================
// reset values and timing
`define DIV_RESET 8'h04
`define SPI_BITS 4'h8
`define SEL_SETUP_NS 100
`define SEL_SETUP_CYC ((`SEL_SETUP_NS + 9) / 10)
`endif

// >>> logic/spi_host_engine.v
`timescale 1ns/1ps
`default_nettype none
module spi_host_engine #(
	parameter BITS = 8
) (
	input wire i_clk,
	input wire i_rstn,
	input wire i_tick,
	input wire i_start,
	input wire [BITS-1:0] i_tx,
	input wire i_miso,
	output reg o_sck,
	output reg o_mosi,
	output reg o_sel_n,
	output reg o_busy,
	output reg o_done,
	output reg [BITS-1:0] o_rx
);
reg [3:0] cnt_q;
reg [BITS-1:0] sh_q;
reg ph_q;
reg [1:0] miso_s;
always @(posedge i_clk) begin
	if (!i_rstn) begin
		cnt_q <= 4'h0;
		sh_q <= {BITS{1'b0}};
		ph_q <= 1'b0;
		o_sck <= 1'b0;
		o_mosi <= 1'b0;
		o_sel_n <= 1'b1;
		o_busy <= 1'b0;
		o_done <= 1'b0;
		o_rx <= {BITS{1'b0}};
		miso_s <= 2'h0;
	end else begin
		// RULE_22 far input synchronised
		miso_s <= {miso_s[0], i_miso};
		o_done <= 1'b0;
		if (!o_busy) begin
			// RULE_01 select falls to open
			if (i_start) begin
				o_busy <= 1'b1;
				o_sel_n <= 1'b0;
				sh_q <= i_tx;
				o_mosi <= i_tx[BITS-1];
				cnt_q <= 4'h0;
				ph_q <= 1'b0;
			end
		end else if (i_tick) begin
			if (!ph_q) begin
				o_sck <= 1'b1;
				// RULE_08 sample mid bit
				sh_q <= {sh_q[BITS-2:0], miso_s[1]};
				ph_q <= 1'b1;
			end else begin
				o_sck <= 1'b0;
				ph_q <= 1'b0;
				cnt_q <= cnt_q + 4'h1;
				o_mosi <= sh_q[BITS-1];
				if (cnt_q == BITS - 1) begin
					// RULE_02 select rises at end
					o_sel_n <= 1'b1;
					o_busy <= 1'b0;
					o_done <= 1'b1;
					o_rx <= sh_q;
				end
			end
		end
	end
end
endmodule // spi_host_engine
`default_nettype wire

// >>> logic/twi_line_monitor.v
`timescale 1ns/1ps
`default_nettype none
module twi_line_monitor (
	input wire i_clk,
	input wire i_rstn,
	input wire i_scl,
	input wire i_sda,
	output wire o_scl,
	output wire o_sda,
	output reg o_start,
	output reg o_stop,
	output reg o_bus_busy
);
reg [1:0] scl_s;
reg [1:0] sda_s;
reg scl_p;
reg sda_p;
assign o_scl = scl_s[1];
assign o_sda = sda_s[1];
always @(posedge i_clk) begin
	if (!i_rstn) begin
		scl_s <= 2'h3;
		sda_s <= 2'h3;
		scl_p <= 1'b1;
		sda_p <= 1'b1;
		o_start <= 1'b0;
		o_stop <= 1'b0;
		o_bus_busy <= 1'b0;
	end else begin
		scl_s <= {scl_s[0], i_scl};
		sda_s <= {sda_s[0], i_sda};
		scl_p <= scl_s[1];
		sda_p <= sda_s[1];
		// RULE_14 sda edge while scl high
		o_start <= scl_s[1] && scl_p && sda_p && !sda_s[1];
		o_stop <= scl_s[1] && scl_p && !sda_p && sda_s[1];
		// RULE_18 busy between start and stop
		if (scl_s[1] && scl_p && sda_p && !sda_s[1])
			o_bus_busy <= 1'b1;
		else if (scl_s[1] && scl_p && !sda_p && sda_s[1])
			o_bus_busy <= 1'b0;
	end
end
endmodule // twi_line_monitor
`default_nettype wire

// >>> logic/serial_port_host.v
// Overview of operation
// RULE_01 - select stays high until ready; falling select opens a transfer
// RULE_02 - select returns high at each transfer end so client resynchronises
// RULE_03 - client needs mode field set to select-controlled client
// RULE_04 - with select low the client shifts and drives its data out
// RULE_05 - select rising makes the client release its data line; the client model drives the inverted bit instead
// RULE_06 - select high or port disable clears client bit counter
// RULE_07 - configuring party enables select control with clock-edge bit set
// RULE_08 - configuring party keeps sample-phase bit clear in client mode
// RULE_09 - host transfer freezes while halted and resumes afterwards
// RULE_10 - client keeps shifting in sleep, flags after eight bits
// RULE_11 - two-wire lines are open drain, pull low for zero
// RULE_12 - host sends start, address byte with direction bit
// RULE_13 - addressed client acknowledges low, roles follow direction bit
// RULE_14 - data changes only while clock low; high reserved for start/stop
// RULE_15 - stop is data rising with clock high; receiver stops instead of ack
// RULE_16 - host may issue repeated start instead of stop
// RULE_17 - host waits while client holds the clock low
// RULE_18 - host tracks start and stop; waits for idle bus
// RULE_19 - transmitter compares sampled data to driven; loses on mismatch
// RULE_20 - losing host releases clock too and waits for stop
// RULE_21 - complete byte sets buffer-full and interrupt flag
// RULE_22 - client select is synchronised before use
//
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "serial_host_defs.vh"
module serial_port_host #(
	parameter BITS = 8
) (
	input wire i_clk,
	input wire i_rstn,
	input wire [3:0] i_addr,
	input wire [7:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	output reg [7:0] o_rdata,
	input wire i_halt,
	output wire o_sck,
	output wire o_mosi,
	input wire i_miso,
	output wire o_sel_n,
	input wire i_scl,
	output wire o_scl_out,
	output wire o_scl_oe,
	input wire i_sda,
	output wire o_sda_out,
	output wire o_sda_oe
);
// ==========================================
// registers
reg [7:0] ctrl_q;
reg [7:0] tx_q;
reg [7:0] div_q;
reg [7:0] divcnt_q;
reg tick_q;
reg spi_done_q;
reg twi_done_q;
reg arb_q;
reg nack_q;
reg [3:0] twi_cmd_q;
reg twi_go_q;
wire spi_busy;
wire spi_done;
wire [7:0] spi_rx;
reg [7:0] rx_q;
function is_reg;
	input [3:0] a;
	input [3:0] r;
	begin
		is_reg = (a == r);
	end
endfunction
// RULE_03 RULE_07 select-controlled client only
wire spi_start = is_reg(i_addr, `REG_CTRL) && i_wr && i_wdata[`CTRL_SPI_GO]
	&& (i_wdata[`CTRL_MODE_MSB:`CTRL_MODE_LSB] == `MODE_CLIENT_SEL);
// ==========================================
// divider
always @(posedge i_clk) begin
	if (!i_rstn) begin
		divcnt_q <= 8'h00;
		tick_q <= 1'b0;
	end else if (i_halt) begin
		// RULE_09 freeze while halted
		tick_q <= 1'b0;
	end else if (spi_start && !spi_busy) begin
		// RULE_01 select leads a full tick
		// miso sync lags two cycles, so a stale first bit otherwise
		divcnt_q <= 8'h00;
		tick_q <= 1'b0;
	end else if (divcnt_q >= div_q) begin
		divcnt_q <= 8'h00;
		tick_q <= 1'b1;
	end else begin
		divcnt_q <= divcnt_q + 8'h01;
		tick_q <= 1'b0;
	end
end
// ==========================================
// spi engine
spi_host_engine #(.BITS(BITS)) u_spi (
	.i_clk(i_clk),
	.i_rstn(i_rstn),
	.i_tick(tick_q),
	.i_start(spi_start),
	.i_tx(tx_q),
	.i_miso(i_miso),
	.o_sck(o_sck),
	.o_mosi(o_mosi),
	.o_sel_n(o_sel_n),
	.o_busy(spi_busy),
	.o_done(spi_done),
	.o_rx(spi_rx)
);
// ==========================================
// two-wire bus
wire scl_s;
wire sda_s;
wire bus_start;
wire bus_stop;
wire bus_busy;
twi_line_monitor u_mon (
	.i_clk(i_clk),
	.i_rstn(i_rstn),
	.i_scl(i_scl),
	.i_sda(i_sda),
	.o_scl(scl_s),
	.o_sda(sda_s),
	.o_start(bus_start),
	.o_stop(bus_stop),
	.o_bus_busy(bus_busy)
);
localparam ST_IDLE = 3'h0;
localparam ST_START = 3'h1;
localparam ST_LOW = 3'h2;
localparam ST_HIGH = 3'h3;
localparam ST_STOP = 3'h4;
localparam ST_STOP2 = 3'h5;
reg [2:0] st_q;
reg [3:0] bit_q;
reg [8:0] sh_q;
reg [7:0] trx_q;
reg scl_drv_q;
reg sda_drv_q;
reg owner_q;
// RULE_11 drive low or release
assign o_scl_out = 1'b0;
assign o_sda_out = 1'b0;
assign o_scl_oe = scl_drv_q;
assign o_sda_oe = sda_drv_q;
always @(posedge i_clk) begin
	if (!i_rstn) begin
		st_q <= ST_IDLE;
		bit_q <= 4'h0;
		sh_q <= 9'h1FF;
		trx_q <= 8'h00;
		scl_drv_q <= 1'b0;
		sda_drv_q <= 1'b0;
		owner_q <= 1'b0;
		twi_done_q <= 1'b0;
		arb_q <= 1'b0;
		nack_q <= 1'b0;
	end else begin
		if (is_reg(i_addr, `REG_TWI_STATUS) && i_rd) begin
			twi_done_q <= 1'b0;
			arb_q <= 1'b0;
			nack_q <= 1'b0;
		end
		case (st_q)
		ST_IDLE: begin
			if (twi_go_q && ctrl_q[`CTRL_TWI_EN]) begin
				if (twi_cmd_q[`TWI_START]) begin
					// RULE_18 wait for idle bus
					if (!bus_busy || owner_q) begin
						if (owner_q) begin
							// RULE_16 repeated start
							sda_drv_q <= 1'b0;
							scl_drv_q <= 1'b0;
						end
						st_q <= ST_START;
					end
				end else if (twi_cmd_q[`TWI_STOP] && !twi_cmd_q[`TWI_READ] && bit_q == 4'h0 && owner_q) begin
					st_q <= ST_STOP;
				end else if (owner_q) begin
					// RULE_12 address or data byte
					sh_q <= twi_cmd_q[`TWI_READ] ? {8'hFF, twi_cmd_q[`TWI_ACK_OUT]} : {tx_q, 1'b1};
					bit_q <= 4'h0;
					st_q <= ST_LOW;
				end
			end
		end
		ST_START: begin
			if (tick_q && scl_s && sda_s) begin
				sda_drv_q <= 1'b1;
				owner_q <= 1'b1;
				st_q <= ST_IDLE;
				twi_done_q <= 1'b1;
			end
		end
		ST_LOW: begin
			scl_drv_q <= 1'b1;
			if (tick_q) begin
				// RULE_14 data changes with clock low
				sda_drv_q <= !sh_q[8];
				st_q <= ST_HIGH;
			end
		end
		ST_HIGH: begin
			if (tick_q) begin
				scl_drv_q <= 1'b0;
				// RULE_17 wait while clock stretched
				if (scl_s && !scl_drv_q) begin
					// RULE_19 compare driven level
					// receiving host leaves data line to client
					if (sh_q[8] && !sda_s && bit_q != 4'h8 && !twi_cmd_q[`TWI_READ]) begin
						// RULE_20 release both lines
						arb_q <= 1'b1;
						sda_drv_q <= 1'b0;
						owner_q <= 1'b0;
						twi_done_q <= 1'b1;
						st_q <= ST_IDLE;
					end else begin
						sh_q <= {sh_q[7:0], sda_s};
						bit_q <= bit_q + 4'h1;
						if (bit_q == 4'h8) begin
							// RULE_13 acknowledge sampled low
							nack_q <= sda_s;
							// RULE_21 byte complete
							trx_q <= sh_q[7:0];
							scl_drv_q <= 1'b1;
							bit_q <= 4'h0;
							// RULE_15 stop in place of next
							st_q <= twi_cmd_q[`TWI_STOP] ? ST_STOP : ST_IDLE;
							if (!twi_cmd_q[`TWI_STOP])
								twi_done_q <= 1'b1;
						end else begin
							scl_drv_q <= 1'b1;
							st_q <= ST_LOW;
						end
					end
				end
			end
		end
		ST_STOP: begin
			scl_drv_q <= 1'b1;
			if (tick_q) begin
				sda_drv_q <= 1'b1;
				st_q <= ST_STOP2;
			end
		end
		ST_STOP2: begin
			if (tick_q) begin
				if (scl_drv_q) begin
					scl_drv_q <= 1'b0;
				end else if (scl_s) begin
					// RULE_15 data rises with clock high
					sda_drv_q <= 1'b0;
					owner_q <= 1'b0;
					twi_done_q <= 1'b1;
					st_q <= ST_IDLE;
				end
			end
		end
		default: st_q <= ST_IDLE;
		endcase
		if (bus_stop && !owner_q)
			arb_q <= arb_q;
	end
end
// ==========================================
// register port
always @(posedge i_clk) begin
	if (!i_rstn) begin
		ctrl_q <= 8'h00;
		tx_q <= 8'h00;
		div_q <= `DIV_RESET;
		twi_cmd_q <= 4'h0;
		twi_go_q <= 1'b0;
		spi_done_q <= 1'b0;
		rx_q <= 8'h00;
		o_rdata <= 8'h00;
	end else begin
		if (st_q != ST_IDLE)
			twi_go_q <= 1'b0;
		if (i_wr) begin
			if (is_reg(i_addr, `REG_CTRL))
				ctrl_q <= i_wdata;
			if (is_reg(i_addr, `REG_TXDATA))
				tx_q <= i_wdata;
			if (is_reg(i_addr, `REG_DIV))
				div_q <= i_wdata;
			if (is_reg(i_addr, `REG_TWI_CTRL)) begin
				twi_cmd_q <= i_wdata[3:0];
				twi_go_q <= 1'b1;
			end
		end
		o_rdata <= 8'h00;
		if (i_rd) begin
			if (is_reg(i_addr, `REG_CTRL))
				o_rdata <= ctrl_q;
			if (is_reg(i_addr, `REG_STATUS))
				o_rdata <= {6'h00, spi_done_q, spi_busy};
			if (is_reg(i_addr, `REG_RXDATA))
				o_rdata <= spi_done_q ? rx_q : trx_q;
			if (is_reg(i_addr, `REG_TWI_STATUS))
				o_rdata <= {1'b0, bus_busy, nack_q, arb_q, twi_done_q, st_q != ST_IDLE, 2'h0};
			if (is_reg(i_addr, `REG_DIV))
				o_rdata <= div_q;
		end
		// RULE_21 set wins over clear
		if (spi_done) begin
			spi_done_q <= 1'b1;
			rx_q <= spi_rx;
		end else if (i_rd && is_reg(i_addr, `REG_RXDATA))
			spi_done_q <= 1'b0;
	end
end
endmodule // serial_port_host
`default_nettype wire

// >>> verification/serial_port_host_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "serial_host_defs.vh"
// ==========================================
// port checker of the serial host
module serial_port_host_assertions #(
	parameter BITS = 8
) (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic [3:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] o_rdata,
	input wire logic i_halt,
	input wire logic o_sck,
	input wire logic o_mosi,
	input wire logic i_miso,
	input wire logic o_sel_n,
	input wire logic i_scl,
	input wire logic o_scl_out,
	input wire logic o_scl_oe,
	input wire logic i_sda,
	input wire logic o_sda_out,
	input wire logic o_sda_oe
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	sequence spi_go;
		i_wr && i_addr == `REG_CTRL && i_wdata[0] && i_wdata[7:4] == `MODE_CLIENT_SEL;
	endsequence
	open_sel_a: assert property (spi_go ##0 (o_sel_n && !i_halt) |=> !o_sel_n)
		else $error("select did not fall after go");
	mode_gate_a: assert property ($fell(o_sel_n) |-> $past(i_wr && i_addr == `REG_CTRL
		&& i_wdata[0] && i_wdata[7:4] == `MODE_CLIENT_SEL))
		else $error("select fell without client mode go");
	sck_sel_a: assert property (o_sck |-> !o_sel_n)
		else $error("clock high while deselected");
	sel_end_a: assert property ($rose(o_sel_n) |-> !o_sck ##1 o_sel_n)
		else $error("select rose badly");
	mosi_edge_a: assert property ($changed(o_mosi) && !o_sel_n && $past(!o_sel_n) |-> !o_sck)
		else $error("data moved with clock high");
	halt_hold_a: assert property (i_halt [*3] |-> $stable(o_sck) && $stable(o_sel_n))
		else $error("transfer moved while halted");
	sck_high_a: assert property ($rose(o_sck) |-> o_sck [*5])
		else $error("clock high phase short");
	open_drain_a: assert property (o_scl_out == 1'b0 && o_sda_out == 1'b0)
		else $error("open drain line driven high");
	rd_zero_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
		else $error("read data outside read slot");
endmodule // serial_port_host_assertions
bind serial_port_host serial_port_host_assertions #(.BITS(BITS)) chk (.*);
`default_nettype wire

// >>> verification/spi_client_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// select-synchronised spi client
module spi_client_model #(
	parameter logic [7:0] REPLY = 8'hA5
) (
	input wire logic i_sck,
	input wire logic i_sel_n,
	input wire logic i_mosi,
	output logic o_miso,
	output logic [7:0] o_rx
);
	logic [7:0] tx_q = 8'h00;
	logic [7:0] sh_q = 8'h00;
	int cnt = 0;
	always @(negedge i_sel_n) begin
		tx_q = REPLY;
		cnt = 0;
	end
	always @(posedge i_sel_n) cnt = 0;
	always @(posedge i_sck) if (!i_sel_n) begin
		sh_q = {sh_q[6:0], i_mosi};
		cnt++;
		if (cnt == 8) begin
			o_rx = sh_q;
			cnt = 0;
		end
	end
	always @(negedge i_sck) if (!i_sel_n) tx_q = {tx_q[6:0], 1'b0};
	// drive while selected; deselected line is driven to the inverted bit, never a stale value
	assign o_miso = i_sel_n ? ~tx_q[7] : tx_q[7];
endmodule // spi_client_model
`default_nettype wire

// >>> verification/serial_port_host_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "serial_host_defs.vh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_count++; \
	$display("[FAIL] t=%0t got %0h exp %0h", $time, a, e); end end
// ==========================================
// bench of the serial host
module serial_port_host_tb;
	logic i_clk = 0, i_rstn = 0, i_wr = 0, i_rd = 0, i_halt = 0, ext_sda = 0;
	logic [3:0] i_addr = 4'h0;
	logic [7:0] i_wdata = 8'h00, d, rx;
	wire [7:0] o_rdata;
	wire o_sck, o_mosi, o_sel_n, miso, scl_oe, sda_oe;
	// pull-ups: a line is low only while someone pulls it
	wire scl = !scl_oe;
	wire sda = !(sda_oe || ext_sda);
	int err_count = 0, checks = 0, n;
	logic [20:0] rows [7] = '{{1'b1, 4'hF, 8'hFF, 8'h00}, {1'b0, 4'hF, 8'h00, 8'h00},
		{1'b0, `REG_STATUS, 8'h00, 8'h00}, {1'b0, `REG_TWI_STATUS, 8'h00, 8'h00},
		{1'b0, `REG_DIV, 8'h00, `DIV_RESET}, {1'b1, `REG_TXDATA, 8'h3C, 8'h00},
		{1'b0, `REG_RXDATA, 8'h00, 8'h00}};
	always #5 i_clk = ~i_clk;
	serial_port_host #(.BITS(8)) uut (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_halt(i_halt),
		.o_sck(o_sck), .o_mosi(o_mosi), .i_miso(miso), .o_sel_n(o_sel_n), .i_scl(scl),
		.o_scl_out(), .o_scl_oe(scl_oe), .i_sda(sda), .o_sda_out(), .o_sda_oe(sda_oe));
	spi_client_model #(.REPLY(8'hA5)) far (.i_sck(o_sck), .i_sel_n(o_sel_n), .i_mosi(o_mosi),
		.o_miso(miso), .o_rx(rx));
	task automatic complete_run();
		$display("checks=%0d err_count=%0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// one gap cycle so a strobe is never set twice in one step
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		i_addr <= a;
		i_wdata <= v;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
		@(posedge i_clk);
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 v = o_rdata;
		@(posedge i_clk);
	endtask
	task automatic spi(input logic [7:0] tx, input bit hold);
		wr(`REG_TXDATA, tx);
		wr(`REG_CTRL, 8'h41);
		if (hold) begin
			repeat (30) @(posedge i_clk);
			i_halt <= 1'b1;
			repeat (40) @(posedge i_clk);
			`CHK(o_sel_n, 1'b0)
			i_halt <= 1'b0;
		end
		for (n = 0; n < 2000 && o_sel_n !== 1'b1; n++) @(posedge i_clk);
		rd(`REG_STATUS, d);
		`CHK(d[`ST_SPI_DONE], 1'b1)
		rd(`REG_RXDATA, d);
		`CHK(d, 8'hA5)
		`CHK(rx, tx)
		$display("spi byte %0h done", tx);
	endtask
	task automatic twi_idle();
		for (n = 0; n < 300; n++) begin
			rd(`REG_TWI_STATUS, d);
			if (d[`ST_TWI_BUSY] === 1'b0) break;
		end
	endtask
	initial begin
		#300000;
		err_count++;
		complete_run();
	end
	initial begin
		repeat (12) @(posedge i_clk);
		i_rstn <= 1'b1;
		@(posedge i_clk);
		foreach (rows[i]) begin
			if (rows[i][20]) wr(rows[i][19:16], rows[i][15:8]);
			else begin
				rd(rows[i][19:16], d);
				`CHK(d, rows[i][7:0])
			end
		end
		$display("register table done");
		spi(8'h3C, 0);
		spi(8'h81, 1);
		for (int m = 0; m < 16; m++) if (m != 4) begin
			wr(`REG_CTRL, {m[3:0], 4'h1});
			repeat (3) @(posedge i_clk);
			`CHK(o_sel_n, 1'b1)
		end
		$display("mode gate done");
		wr(`REG_TXDATA, 8'h5A);
		wr(`REG_CTRL, 8'h41);
		repeat (20) @(posedge i_clk);
		i_rstn <= 1'b0;
		repeat (2) @(posedge i_clk);
		#1 `CHK({o_sel_n, o_sck, scl_oe, sda_oe}, 4'h8)
		i_rstn <= 1'b1;
		@(posedge i_clk);
		spi(8'h96, 0);
		wr(`REG_CTRL, 8'h02);
		ext_sda <= 1'b1;
		repeat (10) @(posedge i_clk);
		rd(`REG_TWI_STATUS, d);
		`CHK(d[`ST_BUS_BUSY], 1'b1)
		wr(`REG_TWI_CTRL, 8'h01);
		repeat (100) @(posedge i_clk);
		`CHK(sda_oe, 1'b0)
		ext_sda <= 1'b0;
		for (n = 0; n < 500 && sda_oe !== 1'b1; n++) @(posedge i_clk);
		`CHK(sda_oe, 1'b1)
		twi_idle();
		wr(`REG_TXDATA, 8'hFF);
		ext_sda <= 1'b1;
		wr(`REG_TWI_CTRL, 8'h00);
		twi_idle();
		`CHK(d[`ST_ARB_LOST], 1'b1)
		`CHK({scl_oe, sda_oe}, 2'b00)
		ext_sda <= 1'b0;
		$display("arbitration done");
		complete_run();
	end
endmodule // serial_port_host_tb
`default_nettype wire
